// ==== core/rx_cfg_pkg.sv ====
// Register map, field layout and timing constants of the receiver configuration bank
package rx_cfg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_RECEIVE_CONTROL = 8'h35;
	localparam logic [7:0] IDX_RECEIVE_HOLDOFF = 8'h36;
	localparam logic [7:0] IDX_RECEIVE_DECODER_THRESHOLD = 8'h37;
	localparam logic [7:0] IDX_RECEIVER_INPUT_MODE = 8'h38;
	localparam logic [7:0] IDX_RECEIVER_ANALOG_SETUP = 8'h39;
	localparam logic [7:0] IDX_RECEIVE_STATUS = 8'h3a;
	// Writable bit masks; others are reserved
	localparam logic [7:0] MASK_RECEIVE_CONTROL = 8'h1f;
	localparam logic [7:0] MASK_RECEIVE_HOLDOFF = 8'hff;
	localparam logic [7:0] MASK_THRESHOLD = 8'hff;
	localparam logic [7:0] MASK_INPUT_MODE = 8'hf3;
	localparam logic [7:0] MASK_ANALOG_SETUP = 8'hcf;
	// Reset values
	localparam logic [7:0] RST_RECEIVE_CONTROL = 8'h04;
	localparam logic [7:0] RST_RECEIVE_HOLDOFF = 8'h00;
	localparam logic [7:0] RST_THRESHOLD = 8'h00;
	localparam logic [7:0] RST_INPUT_MODE = 8'h00;
	localparam logic [7:0] RST_ANALOG_SETUP = 8'h00;
	// Field positions
	localparam int BIT_GUARD_CHECK = 4;
	localparam int BIT_SUPPRESS = 3;
	localparam int BIT_HOLDOFF_UNIT = 7;
	localparam int BIT_SINGLE_INPUT = 7;
	localparam int BIT_CONVERTER_MODE = 6;
	// Baud codes
	localparam logic [2:0] BAUD_106 = 3'h4;
	localparam logic [2:0] BAUD_212 = 3'h5;
	localparam logic [2:0] BAUD_424 = 3'h6;
	localparam logic [2:0] BAUD_847 = 3'h7;
	localparam logic [1:0] COLL_OFF = 2'h3;
	localparam int SUPPRESS_BYTES = 3;
	// Timing at 40 MHz
	localparam real CLK_MHZ = 40.0;
	localparam real CARRIER_MHZ = 13.56;
	localparam int CARRIER_PER_UNIT = 16;
	localparam int UNIT_CARRIER_CYC = int'($floor(CARRIER_PER_UNIT * CLK_MHZ / CARRIER_MHZ));
	// Half bit at 106 kBd is 64 carrier periods; faster rates halve it
	localparam int HALF_BIT_106_CARRIER = 64;
	localparam int HALF_BIT_106_CYC = int'($floor(HALF_BIT_106_CARRIER * CLK_MHZ / CARRIER_MHZ));
	// Guard-time limit in half bits, beyond which a protocol error is flagged
	localparam int GUARD_LIMIT_HALF_BITS = 4;
	typedef enum logic [1:0] {RX_IDLE, RX_HOLDOFF, RX_FRAME} rx_state_t;
endpackage : rx_cfg_pkg

// ==== core/rx_cfg_bank.sv ====
// Receiver configuration register bank with hold-off, guard-time and disturbance logic
`timescale 1ns/1ps
module rx_cfg_bank
	import rx_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Receive datapath events, same clock
	input wire logic tx_done_i,
	input wire logic sof_i,
	input wire logic byte_i,
	input wire logic char_start_i,
	input wire logic byte_err_i,
	input wire logic collision_i,
	input wire logic eof_i,
	input wire logic type_b_i,
	// Analog side, same clock
	input wire logic [3:0] amplitude_i,
	input wire logic [3:0] phase_i,
	// Decoded controls
	output logic input_enable_o,
	output logic data_accept_o,
	output logic phase_accept_o,
	output logic protocol_error_o,
	output logic disturbance_error_o,
	output logic fifo_flush_o,
	output logic rx_complete_o,
	output logic [1:0] baud_select_o,
	output logic baud_valid_o,
	output logic quasi_diff_o,
	output logic low_power_card_detect_o,
	output logic [1:0] signal_source_select_o,
	output logic collision_detect_enable_o,
	output logic [1:0] collision_sensitivity_o,
	output logic [1:0] factory_trim_field_o,
	output logic [1:0] highpass_select_o,
	output logic [1:0] gain_select_o
);
	logic [7:0] receive_control_reg;
	logic [7:0] receive_holdoff_reg;
	logic [7:0] threshold_reg;
	logic [7:0] input_mode_reg;
	logic [7:0] analog_setup_reg;
	logic [7:0] status_reg;
	logic [7:0] rd_next;
	logic hit_next;
	logic wr_stb;
	logic [7:0] wdat;
	logic [7:0] idx;
	rx_state_t state_reg;
	logic [15:0] tick_reg;
	logic [6:0] hold_cnt_reg;
	logic [15:0] unit_len;
	logic [15:0] half_bit;
	logic [1:0] byte_cnt_reg;
	logic [15:0] guard_cnt_reg;
	logic err_ev;
	logic suppress;

	assign idx = wb_adr_i[9:2];
	assign wdat = wb_dat_i[7:0];
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && wb_sel_i[0];
	assign suppress = receive_control_reg[BIT_SUPPRESS];

	always_comb
	begin
		hit_next = 1'b1;
		rd_next = 8'h00;
		unique case (idx)
			IDX_RECEIVE_CONTROL: rd_next = receive_control_reg;
			IDX_RECEIVE_HOLDOFF: rd_next = receive_holdoff_reg;
			IDX_RECEIVE_DECODER_THRESHOLD: rd_next = threshold_reg;
			IDX_RECEIVER_INPUT_MODE: rd_next = input_mode_reg;
			IDX_RECEIVER_ANALOG_SETUP: rd_next = analog_setup_reg;
			IDX_RECEIVE_STATUS: rd_next = status_reg;
			default: hit_next = 1'b0;
		endcase
	end

	// One-cycle answer; unmapped addresses get err
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit_next;
	end

	// Unmapped writes land nowhere as no register decodes their index; the refusal only ends the cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_err_o <= 1'b0;
		else
			wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit_next;
	end

	// Read data registered every cycle; only meaningful with ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else
			wb_dat_o <= {24'h00_0000, rd_next};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			receive_control_reg <= RST_RECEIVE_CONTROL;
		else if (wr_stb && idx == IDX_RECEIVE_CONTROL)
			receive_control_reg <= wdat & MASK_RECEIVE_CONTROL;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			receive_holdoff_reg <= RST_RECEIVE_HOLDOFF;
		else if (wr_stb && idx == IDX_RECEIVE_HOLDOFF)
			receive_holdoff_reg <= wdat & MASK_RECEIVE_HOLDOFF;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			threshold_reg <= RST_THRESHOLD;
		else if (wr_stb && idx == IDX_RECEIVE_DECODER_THRESHOLD)
			threshold_reg <= wdat & MASK_THRESHOLD;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			input_mode_reg <= RST_INPUT_MODE;
		else if (wr_stb && idx == IDX_RECEIVER_INPUT_MODE)
			input_mode_reg <= wdat & MASK_INPUT_MODE;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			analog_setup_reg <= RST_ANALOG_SETUP;
		else if (wr_stb && idx == IDX_RECEIVER_ANALOG_SETUP)
			analog_setup_reg <= wdat & MASK_ANALOG_SETUP;
	end

	always_comb
	begin
		baud_valid_o = 1'b1;
		unique case (receive_control_reg[2:0])
			BAUD_106: baud_select_o = 2'd0;
			BAUD_212: baud_select_o = 2'd1;
			BAUD_424: baud_select_o = 2'd2;
			BAUD_847: baud_select_o = 2'd3;
			default:
			begin
				baud_select_o = 2'd0;
				baud_valid_o = 1'b0;
			end
		endcase
	end

	assign half_bit = 16'(HALF_BIT_106_CYC) >> baud_select_o;
	assign unit_len = receive_holdoff_reg[BIT_HOLDOFF_UNIT] ? half_bit : 16'(UNIT_CARRIER_CYC);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= RX_IDLE;
			tick_reg <= 16'h0000;
			hold_cnt_reg <= 7'h00;
		end
		else if (tx_done_i)
		begin
			tick_reg <= 16'h0000;
			hold_cnt_reg <= receive_holdoff_reg[6:0];
			state_reg <= (receive_holdoff_reg[6:0] == 7'h00) ? RX_IDLE : RX_HOLDOFF;
		end
		else
		begin
			unique case (state_reg)
				RX_IDLE:
				begin
					// Sof in hold-off never reaches here, so it is dropped
					if (sof_i)
						state_reg <= RX_FRAME;
				end
				RX_HOLDOFF:
				begin
					if (tick_reg >= unit_len - 16'h0001)
					begin
						tick_reg <= 16'h0000;
						hold_cnt_reg <= hold_cnt_reg - 7'h01;
						if (hold_cnt_reg == 7'h01) state_reg <= RX_IDLE;
					end
					else
						tick_reg <= tick_reg + 16'h0001;
				end
				RX_FRAME:
				begin
					// Frame stays open after an error flush; later bytes count afresh
					if (eof_i)
						state_reg <= RX_IDLE;
				end
				default: state_reg <= RX_IDLE;
			endcase
		end
	end
	// Gate opens in the cycle after the last count ends
	assign input_enable_o = (state_reg != RX_HOLDOFF);

	// collision counts as error under suppression
	assign err_ev = byte_err_i || (suppress && collision_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			byte_cnt_reg <= 2'd0;
			fifo_flush_o <= 1'b0;
			disturbance_error_o <= 1'b0;
			rx_complete_o <= 1'b0;
		end
		else
		begin
			fifo_flush_o <= 1'b0;
			disturbance_error_o <= 1'b0;
			rx_complete_o <= 1'b0;
			if (sof_i && input_enable_o)
				byte_cnt_reg <= 2'd0;
			else if (state_reg == RX_FRAME)
			begin
				if (suppress && err_ev && byte_cnt_reg < 2'(SUPPRESS_BYTES))
				begin
					fifo_flush_o <= 1'b1;
					disturbance_error_o <= 1'b1;
					byte_cnt_reg <= 2'd0;
				end
				else if (eof_i)
				begin
					if (suppress && byte_cnt_reg < 2'(SUPPRESS_BYTES))
					begin
						fifo_flush_o <= 1'b1;
						disturbance_error_o <= 1'b1;
					end
					else
						rx_complete_o <= 1'b1;
				end
				else if (byte_i && byte_cnt_reg < 2'(SUPPRESS_BYTES))
					byte_cnt_reg <= byte_cnt_reg + 2'd1;
			end
		end
	end

	// guard time check, Type B only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			guard_cnt_reg <= 16'h0000;
			protocol_error_o <= 1'b0;
		end
		else
		begin
			protocol_error_o <= 1'b0;
			if (byte_i || char_start_i || state_reg != RX_FRAME)
				guard_cnt_reg <= 16'h0000;
			else if (guard_cnt_reg != 16'hffff)
				guard_cnt_reg <= guard_cnt_reg + 16'h0001;
			// Exact match gives a single pulse per overlong gap
			if (receive_control_reg[BIT_GUARD_CHECK] && type_b_i && state_reg == RX_FRAME &&
				guard_cnt_reg == 16'(GUARD_LIMIT_HALF_BITS) * half_bit)
				protocol_error_o <= 1'b1;
		end
	end

	// Sticky-free live status: state, early byte count, hold-off busy
	assign status_reg = {3'b000, byte_cnt_reg, state_reg == RX_FRAME, !input_enable_o, baud_valid_o};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_accept_o <= 1'b0;
			phase_accept_o <= 1'b0;
		end
		else
		begin
			data_accept_o <= amplitude_i > threshold_reg[7:4];
			phase_accept_o <= phase_i > threshold_reg[3:0];
		end
	end
	assign quasi_diff_o = input_mode_reg[BIT_SINGLE_INPUT];
	assign low_power_card_detect_o = input_mode_reg[BIT_CONVERTER_MODE];
	assign signal_source_select_o = input_mode_reg[5:4];
	assign collision_sensitivity_o = input_mode_reg[1:0];
	assign collision_detect_enable_o = input_mode_reg[1:0] != COLL_OFF;
	assign factory_trim_field_o = analog_setup_reg[7:6];
	assign highpass_select_o = analog_setup_reg[3:2];
	assign gain_select_o = analog_setup_reg[1:0];
endmodule : rx_cfg_bank

// ==== bench/rx_cfg_bank_properties.sv ====
// Port checker of the receiver configuration bank
`timescale 1ns/1ps
module rx_cfg_bank_properties(
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// Receive events and controls
	input wire logic tx_done_i,
	input wire logic byte_err_i,
	input wire logic collision_i,
	input wire logic eof_i,
	input wire logic type_b_i,
	input wire logic input_enable_o,
	input wire logic protocol_error_o,
	input wire logic disturbance_error_o,
	input wire logic fifo_flush_o,
	input wire logic rx_complete_o,
	input wire logic collision_detect_enable_o,
	input wire logic [1:0] collision_sensitivity_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_unmapped;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && (wb_adr_i[9:2] < 8'h35 || wb_adr_i[9:2] > 8'h3a)
			|=> wb_err_o && !wb_ack_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_upper_zero;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved read bits set");
	property p_holdoff_cause;
		$fell(input_enable_o) |-> $past(tx_done_i);
	endproperty
	a_holdoff_cause: assert property (p_holdoff_cause) else $error("input blocked without transmission");
	// Shortest unit is a half bit at the fastest rate
	property p_holdoff_min;
		$fell(input_enable_o) |-> !input_enable_o [*8];
	endproperty
	a_holdoff_min: assert property (p_holdoff_min) else $error("hold-off too short");
	property p_flush_cause;
		fifo_flush_o |-> disturbance_error_o && $past(byte_err_i || collision_i || eof_i);
	endproperty
	a_flush_cause: assert property (p_flush_cause) else $error("flush without cause");
	property p_no_complete;
		disturbance_error_o |-> !rx_complete_o;
	endproperty
	a_no_complete: assert property (p_no_complete) else $error("complete on disturbance");
	property p_guard_type;
		protocol_error_o |-> $past(type_b_i, 1);
	endproperty
	a_guard_type: assert property (p_guard_type) else $error("guard error outside Type B");
	property p_coll_off;
		collision_detect_enable_o == (collision_sensitivity_o != 2'h3);
	endproperty
	a_coll_off: assert property (p_coll_off) else $error("collision enable wrong");
	cover property ($fell(input_enable_o));
	cover property (fifo_flush_o);
	cover property (protocol_error_o);
endmodule : rx_cfg_bank_properties

// ==== bench/card_model.sv ====
// Card answering frames over the field
`timescale 1ns/1ps
module card_model(
	// Clock
	input wire logic clk_i,
	// Frame events
	output logic sof_o,
	output logic byte_o,
	output logic char_start_o,
	output logic byte_err_o,
	output logic collision_o,
	output logic eof_o
);
	logic [5:0] ev = 6'h0;
	assign {eof_o, collision_o, byte_err_o, char_start_o, byte_o, sof_o} = ev;
	// Idle between frames, so stray events never leak
	task pulse(input int b);
		@(posedge clk_i);
		ev <= 6'h1 << b;
		@(posedge clk_i);
		ev <= 6'h0;
	endtask : pulse
	task frame(input int n, input int at, input int b, input int gap);
		pulse(0);
		for (int i = 0; i < n; i++)
		begin
			pulse(2);
			pulse(1);
			if (i == at)
				pulse(b);
		end
		repeat (gap) @(posedge clk_i);
		pulse(5);
	endtask : frame
endmodule : card_model

// ==== bench/rx_cfg_bank_tb.sv ====
// Testbench of the receiver configuration bank
`timescale 1ns/1ps
module rx_cfg_bank_tb;
	import rx_cfg_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_done = 1'b0, type_b = 1'b0;
	logic [9:0] adr = 10'h0;
	logic [3:0] sel = 4'h1, lane = 4'h1, amp = 4'h0, ph = 4'h0;
	logic [31:0] wdat = 32'h0, dat_o;
	logic ack, err, ien, dacc, pacc, perr, derr, flush, cmpl, bval, qd, low_power_card_detect, cen, sof, byt, chs, berr, coll, eof;
	logic [1:0] bsel, src, cs, trim, hp, gain;
	logic [7:0] rdat, ridx [5] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
	logic [7:0] rrst [5] = '{RST_RECEIVE_CONTROL, RST_RECEIVE_HOLDOFF, RST_THRESHOLD, RST_INPUT_MODE, RST_ANALOG_SETUP};
	logic [7:0] rmsk [5] = '{MASK_RECEIVE_CONTROL, MASK_RECEIVE_HOLDOFF, MASK_THRESHOLD, MASK_INPUT_MODE, MASK_ANALOG_SETUP};
	logic rerr;
	int miscompares = 0, checks_done = 0, nflush = 0, ndist = 0, ncmpl = 0, nperr = 0;
	always #12.5 clk_i = ~clk_i;
	rx_cfg_bank dut(.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .tx_done_i(tx_done), .sof_i(sof),
		.byte_i(byt), .char_start_i(chs), .byte_err_i(berr), .collision_i(coll), .eof_i(eof), .type_b_i(type_b),
		.amplitude_i(amp), .phase_i(ph), .input_enable_o(ien), .data_accept_o(dacc), .phase_accept_o(pacc),
		.protocol_error_o(perr), .disturbance_error_o(derr), .fifo_flush_o(flush), .rx_complete_o(cmpl),
		.baud_select_o(bsel), .baud_valid_o(bval), .quasi_diff_o(qd), .low_power_card_detect_o(low_power_card_detect),
		.signal_source_select_o(src), .collision_detect_enable_o(cen), .collision_sensitivity_o(cs),
		.factory_trim_field_o(trim), .highpass_select_o(hp), .gain_select_o(gain));
	card_model card(.clk_i, .sof_o(sof), .byte_o(byt), .char_start_o(chs), .byte_err_o(berr),
		.collision_o(coll), .eof_o(eof));
	always @(posedge clk_i)
	begin
		nflush += (flush === 1'b1);
		ndist += (derr === 1'b1);
		ncmpl += (cmpl === 1'b1);
		nperr += (perr === 1'b1);
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		{cyc, stb, we} <= {2'h3, w};
		adr <= {idx, 2'h0};
		sel <= lane;
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		rdat = dat_o[7:0];
		rerr = err;
		{cyc, stb, we} <= 3'h0;
	endtask : acc
	task holdoff(input logic [7:0] v, input int exp);
		int n;
		n = 0;
		acc(1, 8'h36, v);
		@(posedge clk_i);
		tx_done <= 1'b1;
		@(posedge clk_i);
		tx_done <= 1'b0;
		do @(posedge clk_i); while (ien === 1'b0 && ++n > 0);
		chk(n, exp);
	endtask : holdoff
	task tally(input int f, input int d, input int c);
		repeat (4) @(posedge clk_i);
		chk(nflush, f);
		chk(ndist, d);
		chk(ncmpl, c);
	endtask : tally
	task end_of_test;
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test;
	end
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset and reserved bits; trim kept zero
		for (int i = 0; i < 5; i++)
		begin
			acc(0, ridx[i], 8'h0);
			chk(rdat, rrst[i]);
			acc(1, ridx[i], i == 4 ? 8'h3f : 8'hff);
			acc(0, ridx[i], 8'h0);
			chk(rdat, rmsk[i] & (i == 4 ? 8'h3f : 8'hff));
		end
		chk({qd, low_power_card_detect, src, cen, cs}, 7'b1111011);
		chk({trim, hp, gain}, 6'h0f);
		acc(1, 8'h38, 8'h61);
		chk({qd, low_power_card_detect, src, cen, cs}, 7'b0110101);
		for (int c = 0; c < 8; c++)
		begin
			acc(1, 8'h35, 8'(c));
			chk({bval, bval ? bsel : 2'h0}, {c >= 4, c >= 4 ? 2'(c - 4) : 2'h0});
		end
		acc(1, 8'h37, 8'h53);
		amp <= 4'h6;
		ph <= 4'h4;
		repeat (2) @(posedge clk_i);
		chk({dacc, pacc}, 2'h3);
		amp <= 4'h5;
		ph <= 4'h3;
		repeat (2) @(posedge clk_i);
		chk({dacc, pacc}, 2'h0);
		acc(0, 8'h40, 8'h0);
		chk(rerr, 1'b1);
		lane = 4'he;
		acc(1, 8'h37, 8'h0);
		lane = 4'h1;
		acc(0, 8'h37, 8'h0);
		chk(rdat, 8'h53);
		acc(1, 8'h35, 8'h04);
		holdoff(8'h02, 2 * UNIT_CARRIER_CYC);
		holdoff(8'h81, HALF_BIT_106_CYC);
		acc(1, 8'h36, 8'h0);
		card.frame(2, -1, 0, 0);
		tally(0, 0, 1);
		acc(1, 8'h35, 8'h0c);
		card.frame(2, -1, 0, 0);
		tally(1, 1, 1);
		card.frame(3, -1, 0, 0);
		tally(1, 1, 2);
		card.frame(5, 1, 4, 0);
		tally(2, 2, 3);
		card.frame(4, 0, 3, 0);
		tally(3, 3, 4);
		acc(1, 8'h35, 8'h14);
		type_b <= 1'b1;
		card.frame(1, -1, 0, 4 * HALF_BIT_106_CYC + 20);
		repeat (4) @(posedge clk_i);
		chk(nperr, 1);
		end_of_test;
	end
endmodule : rx_cfg_bank_tb
bind rx_cfg_bank rx_cfg_bank_properties props(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .wb_err_o, .tx_done_i, .byte_err_i, .collision_i, .eof_i, .type_b_i, .input_enable_o,
	.protocol_error_o, .disturbance_error_o, .fifo_flush_o, .rx_complete_o, .collision_detect_enable_o,
	.collision_sensitivity_o);
